// ===== include/gsc_defs.svh
// Constants for the gas sensor command port
// Behaviour
// R1: Command is two bytes, never checksummed
// R2: Data words carry one trailing checksum byte
// R3: Answer only header address 0x59
// R4: Work at 100 and 400 kHz
// R5: Write is header, command, optional two parameters
// R6: Controller polls read header until acknowledged
// R7: Busy from command acknowledge; NACK headers meanwhile
// R8: After completion acknowledge read header, send data
// R9: Result word MSB first, then checksum
// R10: Stop sending when a byte is not acknowledged
// R11: Controller ends read with NACK and STOP
// R12: Early NACK plus STOP releases bus cleanly
// R13: Results read once; extra bytes read all ones
// R14: CRC-8 poly 0x31, init 0xFF, no reflection
// R15: Conditioning 0x2612, two parameters, 50 ms
// R16: Conditioning returns one raw VOC word
// R17: Measure 0x2619 returns VOC, NOx in 50 ms
// R18: Self-check 0x280E returns one word, 320 ms
// R19: Unit id 0x3682 returns three words, 1 ms
// R20: Hotplate off 0x3615 returns nothing, goes idle
// R21: Default humidity and temperature keep compensation off
// R22: Conditioning must not exceed 10 s; the controller only raises cond_expired and does not end conditioning
// R23: Bad parameter checksum aborts, state unchanged
`ifndef GSC_DEFS_SVH
`define GSC_DEFS_SVH
`define GSC_ADDR 7'h59
`define GSC_CRC_POLY 8'h31
`define GSC_CRC_INIT 8'hff
`define GSC_CRC_XOUT 8'h00
`define GSC_FILL 8'hff
`define GSC_CMD_COND 16'h2612
`define GSC_CMD_MEAS 16'h2619
`define GSC_CMD_TEST 16'h280e
`define GSC_CMD_OFF 16'h3615
`define GSC_CMD_SNUM 16'h3682
`define GSC_RH_DEF 16'h8000
`define GSC_T_DEF 16'h6666
`define GSC_CLK_HZ 50000000
`define GSC_SCL_HZ 400000
`define GSC_COND_MS 50
`define GSC_MEAS_MS 50
`define GSC_TEST_MS 320
`define GSC_OFF_MS 1
`define GSC_SNUM_MS 1
`define GSC_POLL_MS 1
`define GSC_COND_MAX_S 10
`define GSC_MS_CYC(ms) ((ms) * (`GSC_CLK_HZ / 1000))
`define GSC_QTR_CYC ((`GSC_CLK_HZ + 4 * `GSC_SCL_HZ - 1) / (4 * `GSC_SCL_HZ))
`endif

// ===== include/gsc_pkg.sv
// Types and checksum shared by both ends
`include "gsc_defs.svh"
package gsc_pkg;
  typedef enum logic [2:0] {D_IDLE, D_RX, D_ACKW, D_ACK, D_TX, D_TACK} gsc_dev_st_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_WAIT} gsc_host_st_t;
  typedef enum logic [1:0] {M_IDLE, M_COND, M_MEAS} gsc_mode_t;

  // CRC-8 over one word, high byte first
  function automatic logic [7:0] gsc_crc8(input logic [15:0] w);
    logic [7:0] c;
    c = `GSC_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? `GSC_CRC_POLY : 8'h00); // see R14
    end
    return c ^ `GSC_CRC_XOUT;
  endfunction
endpackage

// ===== include/gsc_if.sv
// Open-drain two-wire link between controller and sensor
`timescale 1ns/1ps
`default_nettype none
interface gsc_if;
  logic scl_o;
  logic scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;
  // Wired-and with pull-ups
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
  modport host (output scl_o, scl_oe, h_sda_o, h_sda_oe, input scl, sda);
  modport dev (output d_sda_o, d_sda_oe, input scl, sda);
endinterface
`default_nettype wire

// ===== verilog/gsc_device.sv
// Sensor end of the command port: target, decoder, execution timer
`timescale 1ns/1ps
`default_nettype none
`include "gsc_defs.svh"
module gsc_device import gsc_pkg::*; #(
  parameter int unsigned COND_CYC = `GSC_MS_CYC(`GSC_COND_MS),
  parameter int unsigned MEAS_CYC = `GSC_MS_CYC(`GSC_MEAS_MS),
  parameter int unsigned TEST_CYC = `GSC_MS_CYC(`GSC_TEST_MS),
  parameter int unsigned OFF_CYC = `GSC_MS_CYC(`GSC_OFF_MS),
  parameter int unsigned SNUM_CYC = `GSC_MS_CYC(`GSC_SNUM_MS)
) (
  input wire logic sys_clk,
  input wire logic nrst,
  gsc_if.dev bus,
  input wire logic [15:0] voc_raw_ticks,
  input wire logic [15:0] nox_raw_ticks,
  input wire logic [15:0] self_test_word,
  input wire logic [47:0] unit_id,
  output logic busy,
  output gsc_mode_t mode,
  output logic hotplate_on,
  output logic humid_comp_en,
  output logic [15:0] rh_word,
  output logic [15:0] temp_word
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {scl_s3_q, scl_s2_q, scl_s1_q} <= 3'h7;
      {sda_s3_q, sda_s2_q, sda_s1_q} <= 3'h7;
    end else begin
      {scl_s3_q, scl_s2_q, scl_s1_q} <= {scl_s2_q, scl_s1_q, bus.scl};
      {sda_s3_q, sda_s2_q, sda_s1_q} <= {sda_s2_q, sda_s1_q, bus.sda};
    end
  end

  // Edge and condition detection, sampled at well over 400 kHz
  assign scl_rise = scl_s2_q & ~scl_s3_q; // see R4
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign bus_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  // ****************************************
  // Protocol and execution state
  // ****************************************
  gsc_dev_st_t st_q, st_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic hdr_q, hdr_d;
  logic rd_q, rd_d;
  logic mack_q, mack_d;
  logic [3:0] bidx_q, bidx_d;
  logic [15:0] cmd_q, cmd_d;
  logic [15:0] pw_q, pw_d;
  logic [15:0] par0_q, par0_d;
  logic [15:0] par1_q, par1_d;
  logic [1:0] tw_q, tw_d;
  logic [1:0] tp_q, tp_d;
  logic [1:0] rdn_q, rdn_d;
  logic [1:0] nres_q, nres_d;
  logic busy_q, busy_d;
  logic [31:0] tmr_q, tmr_d;
  logic [15:0] res_q [4];
  logic [15:0] res_d [4];
  gsc_mode_t mode_q, mode_d;
  logic heat_q, heat_d;
  logic hum_q, hum_d;
  logic [15:0] rh_q, rh_d;
  logic [15:0] tc_q, tc_d;
  logic [7:0] rxb;
  logic [7:0] nb;
  logic go;
  logic known;
  logic np;

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    hdr_d = hdr_q;
    rd_d = rd_q;
    mack_d = mack_q;
    bidx_d = bidx_q;
    cmd_d = cmd_q;
    pw_d = pw_q;
    par0_d = par0_q;
    par1_d = par1_q;
    tw_d = tw_q;
    tp_d = tp_q;
    rdn_d = rdn_q;
    nres_d = nres_q;
    busy_d = busy_q;
    tmr_d = tmr_q;
    res_d = res_q;
    mode_d = mode_q;
    heat_d = heat_q;
    hum_d = hum_q;
    rh_d = rh_q;
    tc_d = tc_q;
    go = 1'b0;
    rxb = {sh_q[6:0], sda_s2_q};
    known = 1'b0;
    np = 1'b0;
    // Next byte to send; beyond the answer length all ones
    if (tw_q >= rdn_q) begin
      nb = `GSC_FILL; // see R13
    end else begin
      case (tp_q)
        2'h0: nb = res_q[tw_q][15:8]; // see R9
        2'h1: nb = res_q[tw_q][7:0];
        default: nb = gsc_crc8(res_q[tw_q]); // see R2
      endcase
    end
    case (st_q)
      D_RX: begin
        if (scl_rise) begin
          sh_d = rxb;
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_d = D_ACKW;
            if (hdr_q) begin
              hdr_d = 1'b0;
              rd_d = rxb[0];
              bidx_d = 4'h0;
              tw_d = 2'h0;
              tp_d = 2'h0;
              if (rxb[7:1] != `GSC_ADDR || busy_q) begin
                st_d = D_IDLE; // see R3 see R7
              end else if (rxb[0]) begin
                rdn_d = nres_q; // see R8
                nres_d = 2'h0; // see R13
              end
            end else begin
              bidx_d = bidx_q + 4'h1;
              case (bidx_q)
                4'h0: cmd_d[15:8] = rxb; // see R1
                4'h1: begin
                  cmd_d[7:0] = rxb;
                  known = 1'b1;
                  case ({cmd_q[15:8], rxb})
                    `GSC_CMD_COND, `GSC_CMD_MEAS: np = 1'b1; // see R15 see R17
                    `GSC_CMD_TEST, `GSC_CMD_OFF, `GSC_CMD_SNUM: np = 1'b0;
                    default: known = 1'b0;
                  endcase
                  if (!known) begin
                    st_d = D_IDLE;
                  end else if (!np) begin
                    go = 1'b1; // see R7
                  end
                end
                4'h2, 4'h5: pw_d[15:8] = rxb; // see R5
                4'h3, 4'h6: pw_d[7:0] = rxb;
                4'h4, 4'h7: begin
                  if (gsc_crc8(pw_q) != rxb) begin
                    st_d = D_IDLE; // see R23
                  end else if (bidx_q == 4'h4) begin
                    par0_d = pw_q;
                  end else begin
                    par1_d = pw_q;
                    go = 1'b1;
                  end
                end
                default: st_d = D_IDLE;
              endcase
              if (busy_q) begin
                st_d = D_IDLE; // see R7
              end
            end
          end
        end
      end
      D_ACKW: begin
        if (scl_fall) begin
          st_d = D_ACK;
        end
      end
      D_ACK: begin
        if (scl_fall) begin
          st_d = rd_q ? D_TX : D_RX;
          if (rd_q) begin
            sh_d = nb;
            tp_d = (tp_q == 2'h2) ? 2'h0 : tp_q + 2'h1;
            tw_d = (tp_q == 2'h2 && tw_q != 2'h3) ? tw_q + 2'h1 : tw_q;
          end
        end
      end
      D_TX: begin
        if (scl_fall) begin
          sh_d = {sh_q[6:0], 1'b0}; // see R9
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_d = D_TACK;
          end
        end
      end
      D_TACK: begin
        if (scl_rise) begin
          mack_d = ~sda_s2_q;
        end
        if (scl_fall) begin
          if (mack_q) begin
            st_d = D_TX;
            sh_d = nb;
            tp_d = (tp_q == 2'h2) ? 2'h0 : tp_q + 2'h1;
            tw_d = (tp_q == 2'h2 && tw_q != 2'h3) ? tw_q + 2'h1 : tw_q;
          end else begin
            st_d = D_IDLE; // see R10 see R12
          end
        end
      end
      default: st_d = D_IDLE;
    endcase
    if (bus_stop) begin
      st_d = D_IDLE; // see R12
    end
    if (bus_start) begin
      st_d = D_RX;
      bit_d = 3'h0;
      hdr_d = 1'b1;
    end
    // Execution timer and results
    if (go) begin
      busy_d = 1'b1;
      case (cmd_d)
        `GSC_CMD_COND: tmr_d = COND_CYC; // see R15
        `GSC_CMD_MEAS: tmr_d = MEAS_CYC; // see R17
        `GSC_CMD_TEST: tmr_d = TEST_CYC; // see R18
        `GSC_CMD_OFF: tmr_d = OFF_CYC;
        default: tmr_d = SNUM_CYC; // see R19
      endcase
    end else if (busy_q) begin
      tmr_d = tmr_q - 32'h1;
      if (tmr_q == 32'h1) begin
        busy_d = 1'b0;
        case (cmd_q)
          `GSC_CMD_COND: begin
            res_d[0] = voc_raw_ticks; // see R16
            nres_d = 2'h1;
            mode_d = M_COND;
            heat_d = 1'b1;
          end
          `GSC_CMD_MEAS: begin
            res_d[0] = voc_raw_ticks; // see R17
            res_d[1] = nox_raw_ticks;
            nres_d = 2'h2;
            mode_d = M_MEAS;
            heat_d = 1'b1;
            rh_d = par0_q;
            tc_d = par1_q;
            hum_d = !(par0_q == `GSC_RH_DEF && par1_q == `GSC_T_DEF); // see R21
          end
          `GSC_CMD_TEST: begin
            res_d[0] = self_test_word; // see R18
            nres_d = 2'h1;
          end
          `GSC_CMD_SNUM: begin
            res_d[0] = unit_id[47:32]; // see R19
            res_d[1] = unit_id[31:16];
            res_d[2] = unit_id[15:0];
            nres_d = 2'h3;
          end
          default: begin
            nres_d = 2'h0; // see R20
            mode_d = M_IDLE;
            heat_d = 1'b0;
            hum_d = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= D_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'hff;
      hdr_q <= 1'b0;
      rd_q <= 1'b0;
      mack_q <= 1'b0;
      bidx_q <= 4'h0;
      cmd_q <= 16'h0000;
      pw_q <= 16'h0000;
      par0_q <= `GSC_RH_DEF;
      par1_q <= `GSC_T_DEF;
      tw_q <= 2'h0;
      tp_q <= 2'h0;
      rdn_q <= 2'h0;
      nres_q <= 2'h0;
      busy_q <= 1'b0;
      tmr_q <= 32'h0;
      res_q <= '{default: 16'h0000};
      mode_q <= M_IDLE;
      heat_q <= 1'b0;
      hum_q <= 1'b0;
      rh_q <= `GSC_RH_DEF;
      tc_q <= `GSC_T_DEF;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      hdr_q <= hdr_d;
      rd_q <= rd_d;
      mack_q <= mack_d;
      bidx_q <= bidx_d;
      cmd_q <= cmd_d;
      pw_q <= pw_d;
      par0_q <= par0_d;
      par1_q <= par1_d;
      tw_q <= tw_d;
      tp_q <= tp_d;
      rdn_q <= rdn_d;
      nres_q <= nres_d;
      busy_q <= busy_d;
      tmr_q <= tmr_d;
      res_q <= res_d;
      mode_q <= mode_d;
      heat_q <= heat_d;
      hum_q <= hum_d;
      rh_q <= rh_d;
      tc_q <= tc_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe = (st_q == D_ACK) | ((st_q == D_TX) & ~sh_q[7]); // see R8
  assign busy = busy_q;
  assign mode = mode_q;
  assign hotplate_on = heat_q;
  assign humid_comp_en = hum_q;
  assign rh_word = rh_q;
  assign temp_word = tc_q;
endmodule
`default_nettype wire

// ===== verilog/gsc_host.sv
// Controller end of the command port: clock divider and byte sequencer
`timescale 1ns/1ps
`default_nettype none
`include "gsc_defs.svh"
module gsc_host import gsc_pkg::*; #(
  parameter int unsigned QTR_CYC = `GSC_QTR_CYC,
  parameter int unsigned POLL_CYC = `GSC_MS_CYC(`GSC_POLL_MS),
  parameter int unsigned COND_MAX_CYC = `GSC_COND_MAX_S * `GSC_CLK_HZ
) (
  input wire logic sys_clk,
  input wire logic nrst,
  gsc_if.host bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic [15:0] req_cmd,
  input wire logic req_param_en,
  input wire logic [15:0] req_param0,
  input wire logic [15:0] req_param1,
  input wire logic [3:0] req_rd_len,
  output logic done,
  output logic nacked,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic cond_expired
);
  // ****************************************
  // Data line synchroniser
  // ****************************************
  logic sda_s1_q, sda_s2_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {sda_s2_q, sda_s1_q} <= 2'h3;
    end else begin
      {sda_s2_q, sda_s1_q} <= {sda_s1_q, bus.sda};
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  gsc_host_st_t st_q, st_d;
  logic [1:0] ph_q, ph_d;
  logic [7:0] div_q, div_d;
  logic [31:0] wt_q, wt_d;
  logic [31:0] cc_q, cc_d;
  logic [3:0] bit_q, bit_d;
  logic [3:0] bidx_q, bidx_d;
  logic [3:0] last_q, last_d;
  logic [7:0] byte_q, byte_d;
  logic rd_q, rd_d, ackb_q, ackb_d;
  logic [15:0] cmd_q, cmd_d, p0_q, p0_d, p1_q, p1_d;
  logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic done_q, done_d, nack_q, nack_d;
  logic rdv_q, rdv_d, cexp_q, cexp_d, cact_q, cact_d;
  logic [7:0] rdd_q, rdd_d;
  logic tick, host_ack;
  logic [7:0] wb;

  assign tick = (div_q == 8'(QTR_CYC - 1)); // see R4
  assign host_ack = rd_q & (bidx_q != 4'h0);

  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    div_d = (st_q == H_IDLE || tick) ? 8'h00 : div_q + 8'h01;
    wt_d = wt_q;
    cc_d = cc_q;
    bit_d = bit_q;
    bidx_d = bidx_q;
    last_d = last_q;
    byte_d = byte_q;
    rd_d = rd_q;
    ackb_d = ackb_q;
    cmd_d = cmd_q;
    p0_d = p0_q;
    p1_d = p1_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    done_d = 1'b0;
    nack_d = nack_q;
    rdv_d = 1'b0;
    rdd_d = rdd_q;
    cact_d = cact_q;
    cexp_d = cexp_q;
    // Byte for the next write position
    case (bidx_q + 4'h1)
      4'h1: wb = cmd_q[15:8]; // see R1
      4'h2: wb = cmd_q[7:0];
      4'h3: wb = p0_q[15:8]; // see R5
      4'h4: wb = p0_q[7:0];
      4'h5: wb = gsc_crc8(p0_q); // see R2
      4'h6: wb = p1_q[15:8];
      4'h7: wb = p1_q[7:0];
      default: wb = gsc_crc8(p1_q);
    endcase
    case (st_q)
      H_IDLE: begin
        if (req_valid) begin
          st_d = H_START;
          ph_d = 2'h0;
          rd_d = req_read;
          cmd_d = req_cmd;
          p0_d = req_param0;
          p1_d = req_param1;
          nack_d = 1'b0;
          last_d = req_read ? req_rd_len : (req_param_en ? 4'h8 : 4'h2);
          if (!req_read) begin
            cact_d = (req_cmd == `GSC_CMD_COND) | (cact_q & req_cmd != `GSC_CMD_MEAS & req_cmd != `GSC_CMD_OFF);
          end
        end
      end
      H_START: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          if (ph_q == 2'h0) begin
            sda_oe_d = 1'b1;
          end else begin
            scl_oe_d = 1'b1;
            st_d = H_BIT;
            ph_d = 2'h0;
            bit_d = 4'h0;
            bidx_d = 4'h0;
            byte_d = {`GSC_ADDR, rd_q}; // see R3
          end
        end
      end
      H_BIT: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_oe_d = (bit_q == 4'h8) ? (host_ack & (bidx_q != last_q)) : ~byte_q[7]; // see R11
            2'h1: scl_oe_d = 1'b0;
            2'h2: begin
              if (bit_q == 4'h8) begin
                ackb_d = sda_s2_q;
              end else begin
                byte_d = {byte_q[6:0], sda_s2_q};
              end
            end
            default: begin
              scl_oe_d = 1'b1;
              bit_d = bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                bit_d = 4'h0;
                if (host_ack) begin
                  rdv_d = 1'b1;
                  rdd_d = byte_q;
                end
                if (!host_ack && ackb_q) begin
                  nack_d = 1'b1; // see R10
                  st_d = H_STOP;
                end else if (bidx_q == last_q) begin
                  st_d = H_STOP; // see R11 see R12
                end else begin
                  bidx_d = bidx_q + 4'h1;
                  byte_d = rd_q ? 8'hff : wb;
                end
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_oe_d = 1'b1;
            2'h1: scl_oe_d = 1'b0;
            2'h2: sda_oe_d = 1'b0;
            default: begin
              st_d = (rd_q && nack_q && bidx_q == 4'h0) ? H_WAIT : H_IDLE; // see R6
              wt_d = POLL_CYC;
              done_d = (st_d == H_IDLE);
            end
          endcase
        end
      end
      H_WAIT: begin
        wt_d = wt_q - 32'h1;
        if (wt_q <= 32'h1) begin
          st_d = H_START; // see R6
          ph_d = 2'h0;
          nack_d = 1'b0;
        end
      end
      default: st_d = H_IDLE;
    endcase
    // Conditioning time watch
    cc_d = cact_q ? ((cc_q == COND_MAX_CYC) ? cc_q : cc_q + 32'h1) : 32'h0;
    cexp_d = cact_q & (cc_q == COND_MAX_CYC); // see R22
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= H_IDLE;
      ph_q <= 2'h0;
      div_q <= 8'h00;
      wt_q <= 32'h0;
      cc_q <= 32'h0;
      bit_q <= 4'h0;
      bidx_q <= 4'h0;
      last_q <= 4'h0;
      byte_q <= 8'hff;
      rd_q <= 1'b0;
      ackb_q <= 1'b0;
      cmd_q <= 16'h0000;
      p0_q <= 16'h0000;
      p1_q <= 16'h0000;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      rdv_q <= 1'b0;
      rdd_q <= 8'h00;
      cact_q <= 1'b0;
      cexp_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      div_q <= div_d;
      wt_q <= wt_d;
      cc_q <= cc_d;
      bit_q <= bit_d;
      bidx_q <= bidx_d;
      last_q <= last_d;
      byte_q <= byte_d;
      rd_q <= rd_d;
      ackb_q <= ackb_d;
      cmd_q <= cmd_d;
      p0_q <= p0_d;
      p1_q <= p1_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      done_q <= done_d;
      nack_q <= nack_d;
      rdv_q <= rdv_d;
      rdd_q <= rdd_d;
      cact_q <= cact_d;
      cexp_q <= cexp_d;
    end
  end

  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_oe_q;
  assign bus.h_sda_o = 1'b0;
  assign bus.h_sda_oe = sda_oe_q;
  assign req_ready = (st_q == H_IDLE);
  assign done = done_q;
  assign nacked = nack_q;
  assign rd_valid = rdv_q;
  assign rd_data = rdd_q;
  assign cond_expired = cexp_q;
endmodule
`default_nettype wire

// ===== testbench/gsc_link_checker.sv
// Checker for the two-wire link between both ends
`timescale 1ns/1ps
`default_nettype none
module gsc_link_checker (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic h_sda_o,
  input wire logic h_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // ************
  // Link framing
  // ************
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  a_start_by_host: assert property (s_start |-> h_sda_oe)
    else $error("start not made by controller");
  a_stop_dev_free: assert property (s_stop |-> !d_sda_oe)
    else $error("sensor holds data at stop");
  a_dev_drive_low: assert property ($rose(d_sda_oe) |-> !scl)
    else $error("sensor drives data while clock high");
  a_dev_free_low: assert property ($fell(d_sda_oe) |-> !scl)
    else $error("sensor releases data while clock high");
  a_no_sda_clash: assert property (scl |-> !(h_sda_oe && d_sda_oe))
    else $error("both ends drive data");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high too short");
  a_scl_low_min: assert property ($fell(scl) |-> (!scl) [*8])
    else $error("clock low too short");
  a_host_sda_edge: assert property (scl && $past(scl) && $changed(h_sda_oe) |-> $changed(sda))
    else $error("controller moves data while clock high without start or stop");
endmodule
`default_nettype wire

// ===== testbench/test_gas_sensor_i2c_command_port.sv
// Testbench for both ends of the command port
`timescale 1ns/1ps
`default_nettype none
`include "gsc_defs.svh"
module test_gas_sensor_i2c_command_port import gsc_pkg::*;;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic req_read = 1'b0;
  logic req_param_en = 1'b0;
  logic [15:0] req_cmd = 16'h0;
  logic [15:0] req_param0 = 16'h0;
  logic [15:0] req_param1 = 16'h0;
  logic [3:0] req_rd_len = 4'h0;
  logic [15:0] voc_raw_ticks = 16'h1a2b;
  logic [15:0] nox_raw_ticks = 16'h3c4d;
  logic [15:0] self_test_word = 16'h00f5;
  logic [47:0] unit_id = 48'h0123456789ab;
  logic req_ready, done, nacked, rd_valid, cond_expired, busy, hotplate_on, humid_comp_en;
  logic [7:0] rd_data;
  logic [15:0] rh_word, temp_word;
  gsc_mode_t mode;
  int n_fail = 0;
  int cmp_count = 0;
  logic [7:0] got[$];
  logic nak_seen = 1'b0;
  gsc_if link();
  gsc_host #(.QTR_CYC(8), .POLL_CYC(100), .COND_MAX_CYC(4000)) gsc_host_i (.sys_clk, .nrst, .bus(link.host),
    .req_valid, .req_ready, .req_read, .req_cmd, .req_param_en, .req_param0, .req_param1, .req_rd_len, .done,
    .nacked, .rd_valid, .rd_data, .cond_expired);
  gsc_device #(.COND_CYC(150), .MEAS_CYC(150), .TEST_CYC(600), .OFF_CYC(100), .SNUM_CYC(100)) gsc_device_i (.sys_clk,
    .nrst, .bus(link.dev), .voc_raw_ticks, .nox_raw_ticks, .self_test_word, .unit_id, .busy, .mode, .hotplate_on,
    .humid_comp_en, .rh_word, .temp_word);
  gsc_link_checker gsc_link_checker_i (.sys_clk, .nrst, .scl_o(link.scl_o), .scl_oe(link.scl_oe),
    .h_sda_o(link.h_sda_o), .h_sda_oe(link.h_sda_oe), .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe),
    .scl(link.scl), .sda(link.sda));
  always #10 sys_clk = ~sys_clk;
  // *************
  // Bench helpers
  // *************
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] crc(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  task automatic chkw(input int i, input logic [15:0] w);
    chk(got[i], w[15:8]);
    chk(got[i+1], w[7:0]);
    chk(got[i+2], crc(w));
  endtask
  task automatic xfer(input logic rd, input logic [15:0] cmd, input logic pe, input logic [15:0] p0,
    input logic [15:0] p1, input logic [3:0] len);
    int k;
    got.delete();
    nak_seen = 1'b0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_read <= rd;
    req_cmd <= cmd;
    req_param_en <= pe;
    req_param0 <= p0;
    req_param1 <= p1;
    req_rd_len <= len;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    for (k = 0; k < 30000; k++) begin
      @(posedge sys_clk);
      if (rd_valid === 1'b1) got.push_back(rd_data);
      if (nacked === 1'b1) nak_seen = 1'b1;
      if (done === 1'b1) break;
    end
    if (k == 30000) begin
      n_fail++;
      $display("[ERR] %0t no done", $time);
      end_of_test();
    end
  endtask
  // *************
  // Test sequence
  // *************
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    xfer(1'h0, `GSC_CMD_SNUM, 1'h0, 16'h0, 16'h0, 4'h0);
    chk(busy, 16'h1);
    xfer(1'h1, 16'h0, 1'h0, 16'h0, 16'h0, 4'h9);
    chk(16'(got.size()), 16'h9);
    chkw(0, unit_id[47:32]);
    chkw(3, unit_id[31:16]);
    chkw(6, unit_id[15:0]);
    xfer(1'h1, 16'h0, 1'h0, 16'h0, 16'h0, 4'h3);
    for (int i = 0; i < 3; i++) chk(got[i], 16'hff);
    $display("unit id test done");
    xfer(1'h0, `GSC_CMD_MEAS, 1'h1, 16'h8000, 16'h6666, 4'h0);
    xfer(1'h1, 16'h0, 1'h0, 16'h0, 16'h0, 4'h7);
    chkw(0, voc_raw_ticks);
    chkw(3, nox_raw_ticks);
    chk(got[6], 16'hff);
    chk(humid_comp_en, 16'h0);
    chk(mode, M_MEAS);
    chk(hotplate_on, 16'h1);
    voc_raw_ticks <= 16'h2b3c;
    nox_raw_ticks <= 16'h4d5e;
    xfer(1'h0, `GSC_CMD_MEAS, 1'h1, 16'h1234, 16'h5678, 4'h0);
    xfer(1'h1, 16'h0, 1'h0, 16'h0, 16'h0, 4'h2);
    chk(16'(got.size()), 16'h2);
    chk(got[0], voc_raw_ticks[15:8]);
    chk(got[1], voc_raw_ticks[7:0]);
    chk(humid_comp_en, 16'h1);
    chk(rh_word, 16'h1234);
    chk(temp_word, 16'h5678);
    $display("measure test done");
    self_test_word <= 16'h00f0;
    xfer(1'h0, `GSC_CMD_TEST, 1'h0, 16'h0, 16'h0, 4'h0);
    xfer(1'h1, 16'h0, 1'h0, 16'h0, 16'h0, 4'h3);
    chkw(0, self_test_word);
    chk(nak_seen, 16'h1);
    chk(mode, M_MEAS);
    xfer(1'h0, `GSC_CMD_OFF, 1'h0, 16'h0, 16'h0, 4'h0);
    xfer(1'h1, 16'h0, 1'h0, 16'h0, 16'h0, 4'h0);
    chk(hotplate_on, 16'h0);
    chk(mode, M_IDLE);
    $display("self check and off test done");
    xfer(1'h0, `GSC_CMD_COND, 1'h1, 16'h8000, 16'h6666, 4'h0);
    chk(cond_expired, 16'h0);
    xfer(1'h1, 16'h0, 1'h0, 16'h0, 16'h0, 4'h4);
    chkw(0, voc_raw_ticks);
    chk(got[3], 16'hff);
    chk(mode, M_COND);
    xfer(1'h0, 16'h1234, 1'h0, 16'h0, 16'h0, 4'h0);
    chk(nacked, 16'h1);
    chk(cond_expired, 16'h1);
    chk(req_ready, 16'h1);
    chk(crc(16'hbeef), 16'h92);
    $display("conditioning test done");
    end_of_test();
  end
endmodule
`default_nettype wire
